/* logic/uart_channel_buffers_status.sv */
// Serial channel data path: receive FIFO, transmit buffer, status and ready-to-send pin.
//
// Overview of operation
// - Select bit set: pin is ready-to-send, driven by receiver and transmitter RTS modes.
// - Select bit clear: pin level is the inverse of output port bit 0.
// - Receive shift register fills a three-deep FIFO; reads take the oldest.
// - Buffers and status are reachable only while the module is not halted.
// - Break sets its flag, takes one slot, blocks entries until half a bit high.
// - Breaks starting mid-character are caught on the next all-zero character time.
// - Framing error when the line is low at the middle of the first stop bit.
// - Parity error in parity modes; in multidrop the flag holds the address bit.
// - Overrun when FIFO full and a character waits; waiting one is lost.
// - Transmitter empty after the last stop bit with nothing held; cleared by load or disable.
// - Transmitter-ready is driven on o_tx_holding_free and mirrored into status bit 2.
// - Transmitter-ready sets on transfer to shifter and on enable; disabled writes lost.
// - FIFO-full sets when a transfer fills all slots; a waiting char refills after a read.
// - Receiver-ready sets on entry into the FIFO, clears when a read empties it.
// - A buffer write clears ready; an idle shifter loads a held character and re-sets ready.
// - Writes while not ready or while disabled leave the buffer untouched.
// - Change-in-break pulses at both the start and the end of a break.
// - Auto-negate clears output bit 0 one bit time after transmission drains.
// - Clear-to-send gating checks the input before each character only.
`timescale 1ns/1ps
`include "uart_channel_cfg.svh"

module uart_channel_buffers_status (
	input  wire logic                              i_mclk,
	input  wire logic                              i_rst_n,
	input  wire logic                              i_baud16_tick,
	input  wire logic                              i_module_halt,
	input  wire uart_channel_pkg::mode_config_type i_mode_config,
	input  wire uart_channel_pkg::command_type     i_command,
	input  wire logic [4:0]                        i_bus_addr,
	input  wire logic                              i_bus_read,
	input  wire logic                              i_bus_write,
	input  wire logic [7:0]                        i_bus_wdata,
	output logic [7:0]                             o_bus_rdata,
	input  wire logic                              i_serial_input_line,
	input  wire logic                              i_clear_to_send_input_n,
	output logic                                   o_serial_output_line,
	output logic                                   o_ready_to_send_a_n,
	output logic                                   o_tx_holding_free,
	output logic                                   o_transmitter_empty,
	output logic                                   o_rx_char_available,
	output logic                                   o_fifo_full,
	output logic                                   o_change_in_break
);
	import uart_channel_pkg::*;

	// ======================================================================
	// Helpers
	function automatic logic [3:0] char_last(input logic [1:0] bpc);
		char_last = {2'h0, bpc} + 4'h4;
	endfunction : char_last

	function automatic logic parity_on(input logic [1:0] mode);
		parity_on = (mode != `PARITY_NONE);
	endfunction : parity_on

	// Parity bit that a correct character carries in the parity-checking modes.
	function automatic logic parity_bit(input logic [7:0] data, input logic [1:0] mode,
		input logic ptype);
		if (mode == `PARITY_WITH) begin
			parity_bit = (^data) ^ ptype;
		end else begin
			parity_bit = ptype;
		end
	endfunction : parity_bit

	function automatic logic [1:0] ring_index(input logic [1:0] base, input logic [1:0] offs);
		logic [2:0] sum;
		sum = {1'b0, base} + {1'b0, offs};
		if (sum > {1'b0, `FIFO_LAST_INDEX}) begin
			sum = sum - {1'b0, `FIFO_DEPTH};
		end
		ring_index = sum[1:0];
	endfunction : ring_index

	function automatic logic [7:0] length_mask(input logic [1:0] bpc);
		length_mask = 8'hFF >> (3'h3 - {1'b0, bpc});
	endfunction : length_mask

	// ======================================================================
	// State
	state_type    state;
	state_type    next_state;
	rx_entry_type new_entry;
	rx_entry_type head_entry;
	logic         new_valid;
	logic         fifo_full;
	logic         bus_ok;
	logic         cts_ok;
	logic [7:0]   status_byte;

	assign fifo_full  = (state.fifo_count == `FIFO_DEPTH);
	assign head_entry = state.fifo[state.fifo_rd];
	assign bus_ok     = !i_module_halt;
	assign cts_ok     = !i_mode_config.clear_to_send_gate || !i_clear_to_send_input_n;

	always_comb begin
		status_byte = `BYTE_RESET;
		if (state.fifo_count != 2'h0) begin
			status_byte[`STATUS_BREAK_BIT]   = head_entry.received_break;
			status_byte[`STATUS_FRAMING_BIT] = head_entry.framing_error;
			status_byte[`STATUS_PARITY_BIT]  = head_entry.parity_error;
		end
		status_byte[`STATUS_OVERRUN_BIT]  = state.overrun;
		status_byte[`STATUS_TX_EMPTY_BIT] = o_transmitter_empty;
		status_byte[`STATUS_TX_FREE_BIT]  = o_tx_holding_free;
		status_byte[`STATUS_FIFO_FULL_BIT] = fifo_full;
		status_byte[`STATUS_RX_AVAIL_BIT] = (state.fifo_count != 2'h0);
	end

	// ======================================================================
	// Next-state logic
	always_comb begin
		next_state = state;
		new_entry  = '0;
		new_valid  = 1'b0;
		next_state.change_in_break = 1'b0;

		// Bus access.
		if (i_bus_read && bus_ok) begin
			if (i_bus_addr == `CHANNEL_STATUS_OFFSET) begin
				next_state.rdata = status_byte;
			end else if (i_bus_addr == `RECEIVE_BUFFER_OFFSET) begin
				next_state.rdata = head_entry.data;
				if (state.fifo_count != 2'h0) begin
					next_state.fifo_rd    = ring_index(state.fifo_rd, 2'h1);
					next_state.fifo_count = state.fifo_count - 2'h1;
				end
			end else begin
				next_state.rdata = `BYTE_RESET;
			end
		end
		if (i_bus_write && bus_ok && i_bus_addr == `TRANSMIT_BUFFER_OFFSET) begin
			if (state.tx_enabled && !state.hold_valid) begin
				next_state.hold_valid = 1'b1;
				next_state.hold_data  = i_bus_wdata;
			end
		end
		if (i_command.reset_error_cmd) begin
			next_state.overrun = 1'b0;
		end

		// Receiver.
		if (i_baud16_tick) begin
			next_state.rx_tick = state.rx_tick + 4'h1;
			case (state.rx_state)
				RX_IDLE: begin
					next_state.rx_tick = 4'h0;
					if (!i_serial_input_line) begin
						next_state.rx_state = RX_START;
					end
				end
				RX_START: begin
					if (state.rx_tick == `TICKS_HALF_BIT_LAST) begin
						next_state.rx_tick  = 4'h0;
						next_state.rx_bit   = 4'h0;
						next_state.rx_shift = `BYTE_RESET;
						next_state.rx_state = i_serial_input_line ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (state.rx_tick == `TICKS_PER_BIT_LAST) begin
						next_state.rx_shift[state.rx_bit[2:0]] = i_serial_input_line;
						next_state.rx_bit = state.rx_bit + 4'h1;
						if (state.rx_bit == char_last(i_mode_config.bits_per_char)) begin
							next_state.rx_state = parity_on(i_mode_config.parity_mode) ?
								RX_PARITY : RX_STOP;
						end
					end
				end
				RX_PARITY: begin
					if (state.rx_tick == `TICKS_PER_BIT_LAST) begin
						next_state.rx_par   = i_serial_input_line;
						next_state.rx_state = RX_STOP;
					end
				end
				RX_STOP: begin
					if (state.rx_tick == `TICKS_PER_BIT_LAST) begin
						new_valid = 1'b1;
						new_entry.data = state.rx_shift & length_mask(i_mode_config.bits_per_char);
						new_entry.framing_error = !i_serial_input_line;
						new_entry.received_break = !i_serial_input_line &&
							(state.rx_shift == `BYTE_RESET) &&
							!(parity_on(i_mode_config.parity_mode) && state.rx_par);
						if (i_mode_config.parity_mode == `PARITY_MULTIDROP) begin
							new_entry.parity_error = state.rx_par;
						end else if (parity_on(i_mode_config.parity_mode)) begin
							new_entry.parity_error = state.rx_par != parity_bit(new_entry.data,
								i_mode_config.parity_mode, i_mode_config.parity_type);
						end
						next_state.rx_tick = 4'h0;
						if (new_entry.received_break) begin
							next_state.in_break        = 1'b1;
							next_state.change_in_break = 1'b1;
							next_state.rx_state        = RX_BREAK_WAIT;
						end else begin
							next_state.rx_state = RX_IDLE;
						end
					end
				end
				RX_BREAK_WAIT: begin
					// Eight 16x periods of high line, i.e. half a bit time.
					if (!i_serial_input_line) begin
						next_state.rx_tick = 4'h0;
					end else if (state.rx_tick == `TICKS_HALF_BIT_LAST) begin
						next_state.in_break        = 1'b0;
						next_state.change_in_break = 1'b1;
						next_state.rx_state        = RX_IDLE;
					end
				end
				default: begin
					next_state.rx_state = RX_IDLE;
				end
			endcase
		end

		// Waiting character moves in as soon as a slot is free, after any read.
		if (next_state.wait_valid && next_state.fifo_count != `FIFO_DEPTH) begin
			next_state.fifo[ring_index(next_state.fifo_rd, next_state.fifo_count)] =
				next_state.wait_entry;
			next_state.fifo_count = next_state.fifo_count + 2'h1;
			next_state.wait_valid = 1'b0;
		end
		if (new_valid) begin
			if (next_state.wait_valid) begin
				next_state.overrun = 1'b1;
			end
			next_state.wait_valid = 1'b1;
			next_state.wait_entry = new_entry;
		end

		// Transmitter.
		if (i_command.op_set_bit0 && bus_ok) begin
			next_state.op_bit0 = 1'b1;
		end
		if (i_command.op_clear_bit0 && bus_ok) begin
			next_state.op_bit0 = 1'b0;
		end
		if (i_command.transmitter_enable_cmd) begin
			next_state.tx_enabled = 1'b1;
		end
		if (i_command.transmitter_disable_cmd) begin
			next_state.tx_enabled = 1'b0;
			next_state.hold_valid = 1'b0;
		end
		case (state.tx_state)
			TX_IDLE: begin
				next_state.line_out = `LINE_IDLE;
				next_state.tx_tick  = 4'h0;
				if (state.hold_valid && state.tx_enabled && cts_ok) begin
					next_state.tx_shift   = state.hold_data;
					next_state.tx_par     = parity_bit(state.hold_data &
						length_mask(i_mode_config.bits_per_char), i_mode_config.parity_mode,
						i_mode_config.parity_type);
					next_state.hold_valid = 1'b0;
					next_state.line_out   = 1'b0;
					next_state.tx_state   = TX_START;
				end
			end
			TX_START, TX_DATA, TX_PARITY, TX_STOP, TX_NEGATE: begin
				if (i_baud16_tick) begin
					next_state.tx_tick = state.tx_tick + 4'h1;
					if (state.tx_tick == `TICKS_PER_BIT_LAST) begin
						case (state.tx_state)
							TX_START: begin
								next_state.tx_bit   = 4'h0;
								next_state.line_out = state.tx_shift[0];
								next_state.tx_state = TX_DATA;
							end
							TX_DATA: begin
								next_state.tx_bit = state.tx_bit + 4'h1;
								if (state.tx_bit == char_last(i_mode_config.bits_per_char)) begin
									if (parity_on(i_mode_config.parity_mode)) begin
										next_state.line_out = state.tx_par;
										next_state.tx_state = TX_PARITY;
									end else begin
										next_state.line_out = `LINE_IDLE;
										next_state.tx_bit   = 4'h0;
										next_state.tx_state = TX_STOP;
									end
								end else begin
									next_state.line_out = state.tx_shift[next_state.tx_bit[2:0]];
								end
							end
							TX_PARITY: begin
								next_state.line_out = `LINE_IDLE;
								next_state.tx_bit   = 4'h0;
								next_state.tx_state = TX_STOP;
							end
							TX_STOP: begin
								next_state.tx_bit = state.tx_bit + 4'h1;
								if (!i_mode_config.two_stop_bits || state.tx_bit != 4'h0) begin
									next_state.tx_state = TX_IDLE;
									if (i_mode_config.transmitter_auto_negate &&
										!i_mode_config.receiver_flow_control &&
										!next_state.hold_valid && state.op_bit0) begin
										next_state.tx_state = TX_NEGATE;
									end
								end
							end
							default: begin
								next_state.op_bit0  = 1'b0;
								next_state.tx_state = TX_IDLE;
							end
						endcase
					end
				end
			end
			default: begin
				next_state.tx_state = TX_IDLE;
			end
		endcase
	end

	// ======================================================================
	// Registers
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state          <= '0;
			state.line_out <= `LINE_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ======================================================================
	// Outputs
	// The holding register and the shifter form the two-entry transmit buffer; a negated
	// clear-to-send stalls the shifter and so holds off the next write through ready.
	assign o_tx_holding_free    = state.tx_enabled && !state.hold_valid;
	assign o_transmitter_empty  = state.tx_enabled && !state.hold_valid &&
		(state.tx_state == TX_IDLE || state.tx_state == TX_NEGATE);
	assign o_rx_char_available  = (state.fifo_count != 2'h0);
	assign o_fifo_full          = fifo_full;
	assign o_bus_rdata          = state.rdata;
	assign o_serial_output_line = state.line_out;
	assign o_change_in_break    = state.change_in_break;

	// Receiver flow control alone drives the pin from FIFO room; with both modes set the
	// configuration is invalid and the pin falls back to the output bit.
	always_comb begin
		if (i_mode_config.pin_zero_function_select && i_mode_config.receiver_flow_control &&
			!i_mode_config.transmitter_auto_negate) begin
			o_ready_to_send_a_n = fifo_full;
		end else begin
			o_ready_to_send_a_n = !state.op_bit0;
		end
	end

endmodule : uart_channel_buffers_status

/* logic/uart_channel_cfg.svh */
// Offsets, field positions, reset values and timing counts of the serial channel.
`ifndef UART_CHANNEL_CFG_SVH
`define UART_CHANNEL_CFG_SVH

// ==========================================================================
// Register offsets (byte registers)
`define CHANNEL_STATUS_OFFSET   5'h11
`define RECEIVE_BUFFER_OFFSET   5'h13
`define TRANSMIT_BUFFER_OFFSET  5'h13

// ==========================================================================
// Status bit positions
`define STATUS_BREAK_BIT        7
`define STATUS_FRAMING_BIT      6
`define STATUS_PARITY_BIT       5
`define STATUS_OVERRUN_BIT      4
`define STATUS_TX_EMPTY_BIT     3
`define STATUS_TX_FREE_BIT      2
`define STATUS_FIFO_FULL_BIT    1
`define STATUS_RX_AVAIL_BIT     0

// Position of the transmitter-ready mirror in the interrupt status byte.
`define INTERRUPT_STATUS_TX_FREE_A_BIT 0
`define INTERRUPT_STATUS_TX_FREE_B_BIT 4

// ==========================================================================
// Parity mode encodings
`define PARITY_WITH             2'h0
`define PARITY_FORCE            2'h1
`define PARITY_NONE             2'h2
`define PARITY_MULTIDROP        2'h3

// ==========================================================================
// Timing counts in 16x ticks, FIFO depth and last index
`define TICKS_PER_BIT_LAST      4'hF
`define TICKS_HALF_BIT_LAST     4'h7
`define FIFO_DEPTH              2'h3
`define FIFO_LAST_INDEX         2'h2

// ==========================================================================
// Reset values
`define BYTE_RESET              8'h00
`define LINE_IDLE               1'b1

`endif

/* logic/uart_channel_pkg.sv */
// Types shared by the serial channel and its environment.
package uart_channel_pkg;

	// ======================================================================
	// State machines
	typedef enum logic [2:0] {
		RX_IDLE       = 3'b000,
		RX_START      = 3'b001,
		RX_DATA       = 3'b010,
		RX_PARITY     = 3'b011,
		RX_STOP       = 3'b100,
		RX_BREAK_WAIT = 3'b101
	} rx_state_type;

	typedef enum logic [2:0] {
		TX_IDLE   = 3'b000,
		TX_START  = 3'b001,
		TX_DATA   = 3'b010,
		TX_PARITY = 3'b011,
		TX_STOP   = 3'b100,
		TX_NEGATE = 3'b101
	} tx_state_type;

	// ======================================================================
	// Carriers
	typedef struct packed {
		logic       received_break;
		logic       framing_error;
		logic       parity_error;
		logic [7:0] data;
	} rx_entry_type;

	typedef struct packed {
		logic [1:0] bits_per_char;
		logic [1:0] parity_mode;
		logic       parity_type;
		logic       two_stop_bits;
		logic       receiver_flow_control;
		logic       transmitter_auto_negate;
		logic       clear_to_send_gate;
		logic       pin_zero_function_select;
	} mode_config_type;

	typedef struct packed {
		logic transmitter_enable_cmd;
		logic transmitter_disable_cmd;
		logic reset_error_cmd;
		logic op_set_bit0;
		logic op_clear_bit0;
	} command_type;

	typedef struct packed {
		rx_state_type          rx_state;
		logic [3:0]            rx_tick;
		logic [3:0]            rx_bit;
		logic [7:0]            rx_shift;
		logic                  rx_par;
		logic                  wait_valid;
		rx_entry_type          wait_entry;
		rx_entry_type [2:0]    fifo;
		logic [1:0]            fifo_rd;
		logic [1:0]            fifo_count;
		logic                  overrun;
		logic                  in_break;
		logic                  change_in_break;
		tx_state_type          tx_state;
		logic [3:0]            tx_tick;
		logic [3:0]            tx_bit;
		logic [7:0]            tx_shift;
		logic                  tx_par;
		logic                  tx_enabled;
		logic                  hold_valid;
		logic [7:0]            hold_data;
		logic                  line_out;
		logic                  op_bit0;
		logic [7:0]            rdata;
	} state_type;

endpackage : uart_channel_pkg

/* verification/uart_channel_sva.sv */
// Concurrent checks on the serial channel ports.
`timescale 1ns/1ps
`include "uart_channel_cfg.svh"
module uart_channel_sva (
	input wire logic                              i_mclk,
	input wire logic                              i_rst_n,
	input wire logic                              i_module_halt,
	input wire uart_channel_pkg::mode_config_type i_mode_config,
	input wire uart_channel_pkg::command_type     i_command,
	input wire logic [4:0]                        i_bus_addr,
	input wire logic                              i_bus_read,
	input wire logic                              i_bus_write,
	input wire logic [7:0]                        o_bus_rdata,
	input wire logic                              o_serial_output_line,
	input wire logic                              o_ready_to_send_a_n,
	input wire logic                              o_tx_holding_free,
	input wire logic                              o_transmitter_empty,
	input wire logic                              o_rx_char_available,
	input wire logic                              o_fifo_full,
	input wire logic                              o_change_in_break
);
	import uart_channel_pkg::*;
	logic rb_rd;
	logic tb_wr;
	assign rb_rd = i_bus_read && !i_module_halt && i_bus_addr == `RECEIVE_BUFFER_OFFSET;
	assign tb_wr = i_bus_write && !i_module_halt && i_bus_addr == `TRANSMIT_BUFFER_OFFSET;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	// ====================
	// Transmit load sequences
	sequence s_write_idle;
		tb_wr && o_tx_holding_free && o_transmitter_empty && !i_mode_config.clear_to_send_gate;
	endsequence
	sequence s_reload;
		!o_tx_holding_free ##1 o_tx_holding_free;
	endsequence
	// ====================
	// Properties
	a_pin_set: assert property (!i_mode_config.pin_zero_function_select &&
		i_command.op_set_bit0 && !i_module_halt |=> !o_ready_to_send_a_n)
		else $error("pin not asserted after set");
	a_pin_clear: assert property (!i_mode_config.pin_zero_function_select &&
		i_command.op_clear_bit0 && !i_module_halt |=> o_ready_to_send_a_n)
		else $error("pin not negated after clear");
	a_flow_pin: assert property (i_mode_config.pin_zero_function_select &&
		i_mode_config.receiver_flow_control && !i_mode_config.transmitter_auto_negate
		|-> o_ready_to_send_a_n == o_fifo_full) else $error("flow pin mismatch");
	a_full_has_data: assert property (o_fifo_full |-> o_rx_char_available)
		else $error("full without data");
	a_avail_drop: assert property ($fell(o_rx_char_available) |-> $past(rb_rd))
		else $error("ready dropped without read");
	a_empty_read: assert property (rb_rd && !o_rx_char_available |=> !o_rx_char_available)
		else $error("empty read changed ready");
	a_halt_read: assert property (i_module_halt && i_bus_read |=> $stable(o_bus_rdata))
		else $error("halted read changed data");
	a_write_load: assert property (s_write_idle |=> s_reload)
		else $error("holding register load timing");
	a_empty_rise: assert property ($rose(o_transmitter_empty) |->
		o_tx_holding_free && o_serial_output_line) else $error("empty with work left");
	a_enable_ready: assert property (i_command.transmitter_enable_cmd && !i_module_halt &&
		!o_tx_holding_free && !o_transmitter_empty |=> o_tx_holding_free)
		else $error("enable did not set ready");
	a_disable_clear: assert property (i_command.transmitter_disable_cmd && !i_module_halt
		|=> !o_tx_holding_free && !o_transmitter_empty) else $error("disable kept flags");
	a_break_pulse: assert property (o_change_in_break |=> !o_change_in_break)
		else $error("break event longer than one cycle");
endmodule : uart_channel_sva

/* verification/uart_remote_model.sv */
// Remote serial device: sends frames to the channel and collects what it transmits.
`timescale 1ns/1ps
module uart_remote_model (
	input  wire logic i_mclk,
	input  wire logic i_baud16_tick,
	input  wire logic i_line,
	output logic      o_line
);
	logic [7:0] rx_q [$];
	logic [8:0] got;
	initial o_line = 1'b1;
	task automatic wait_ticks(input int n);
		repeat (n) @(posedge i_mclk iff i_baud16_tick);
	endtask : wait_ticks
	// ====================
	// Sender
	// Two idle bit times follow each frame so a break always sees its half bit high.
	task automatic send(input logic [11:0] frame, input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge i_mclk);
			o_line = frame[i];
			wait_ticks(16);
		end
		@(negedge i_mclk);
		o_line = 1'b1;
		wait_ticks(32);
	endtask : send
	// ====================
	// Receiver
	// Only eight data bits and one stop bit are taken, which is all the channel is set to send.
	initial begin
		forever begin
			@(negedge i_line);
			wait_ticks(8);
			for (int j = 0; j < 9; j++) begin
				wait_ticks(16);
				got[j] = i_line;
			end
			if (got[8] === 1'b1)
				rx_q.push_back(got[7:0]);
		end
	end
endmodule : uart_remote_model

/* verification/tb_top.sv */
// Self-checking bench for the serial channel data path.
`timescale 1ns/1ps
`include "uart_channel_cfg.svh"
module tb_top;
	import uart_channel_pkg::*;
	typedef struct {
		logic [11:0] frame;
		int          n;
		logic [1:0]  bpc;
		logic [1:0]  pm;
		logic [7:0]  data;
		logic [2:0]  flags;
	} row_type;
	row_type rows [6] = '{
		'{12'h34A, 10, 2'h3, `PARITY_NONE, 8'hA5, 3'h0},
		'{12'h078, 10, 2'h3, `PARITY_NONE, 8'h3C, 3'h2},
		'{12'h402, 11, 2'h3, `PARITY_WITH, 8'h01, 3'h1},
		'{12'h684, 11, 2'h3, `PARITY_MULTIDROP, 8'h42, 3'h1},
		'{12'h06A, 7, 2'h0, `PARITY_NONE, 8'h15, 3'h0},
		'{12'h000, 10, 2'h3, `PARITY_NONE, 8'h00, 3'h6}};
	logic            mclk, rst_n, tick, halt, rd, wr, cts_n, rx_line, tx_line;
	logic            pin_n, free, empty, avail, full, cib;
	logic [4:0]      addr;
	logic [7:0]      wdata, rdata, d;
	mode_config_type cfg;
	command_type     cmd;
	int              fails, checks, cib_count, tcnt;
	uart_channel_buffers_status dut_u (.i_mclk(mclk), .i_rst_n(rst_n), .i_baud16_tick(tick),
		.i_module_halt(halt), .i_mode_config(cfg), .i_command(cmd), .i_bus_addr(addr),
		.i_bus_read(rd), .i_bus_write(wr), .i_bus_wdata(wdata), .o_bus_rdata(rdata),
		.i_serial_input_line(rx_line), .i_clear_to_send_input_n(cts_n),
		.o_serial_output_line(tx_line), .o_ready_to_send_a_n(pin_n), .o_tx_holding_free(free),
		.o_transmitter_empty(empty), .o_rx_char_available(avail), .o_fifo_full(full),
		.o_change_in_break(cib));
	uart_remote_model remote_u (.i_mclk(mclk), .i_baud16_tick(tick), .i_line(tx_line),
		.o_line(rx_line));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// A tick every four clocks keeps a character near 640 cycles.
	always @(negedge mclk) begin
		tcnt = (tcnt + 1) % 4;
		tick = (tcnt == 0);
	end
	always @(posedge mclk) if (cib === 1'b1) cib_count++;
	// ====================
	// Tasks
	task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", name, e, g);
		end
	endtask : chk
	task automatic bus_read(input logic [4:0] a);
		@(negedge mclk);
		addr = a;
		rd = 1'b1;
		@(negedge mclk);
		rd = 1'b0;
		@(negedge mclk);
		d = rdata;
	endtask : bus_read
	task automatic bus_write(input logic [7:0] v);
		@(negedge mclk);
		addr = `TRANSMIT_BUFFER_OFFSET;
		wdata = v;
		wr = 1'b1;
		@(negedge mclk);
		wr = 1'b0;
	endtask : bus_write
	task automatic pulse(input logic [4:0] c);
		@(negedge mclk);
		cmd = command_type'(c);
		@(negedge mclk);
		cmd = '0;
	endtask : pulse
	task automatic wait_empty();
		for (int i = 0; i < 4000 && empty !== 1'b1; i++) @(negedge mclk);
		chk("tx empty", 8'h01, {7'h0, empty});
	endtask : wait_empty
	task automatic print_verdict();
		if (fails == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	initial begin
		#300000;
		fails++;
		print_verdict();
	end
	// ====================
	// Main sequence
	initial begin
		{halt, rd, wr, cmd, addr, wdata, cts_n, rst_n} = '0;
		cfg = '0;
		repeat (20) @(negedge mclk);
		rst_n = 1'b1;
		foreach (rows[i]) begin
			cfg.bits_per_char = rows[i].bpc;
			cfg.parity_mode = rows[i].pm;
			remote_u.send(rows[i].frame, rows[i].n);
			bus_read(`CHANNEL_STATUS_OFFSET);
			chk("rx status", {rows[i].flags, 5'h01}, d);
			bus_read(`RECEIVE_BUFFER_OFFSET);
			chk("rx data", rows[i].data, d);
			chk("rx ready", 8'h00, {7'h0, avail});
		end
		chk("break events", 8'h02, 8'(cib_count));
		cfg.pin_zero_function_select = 1'b1;
		cfg.receiver_flow_control = 1'b1;
		for (int i = 0; i < 5; i++) remote_u.send({1'b1, 8'(8'h10 + i), 1'b0}, 10);
		bus_read(`CHANNEL_STATUS_OFFSET);
		chk("overrun status", 8'h13, d);
		chk("flow pin full", 8'h01, {7'h0, pin_n});
		for (int i = 0; i < 4; i++) begin
			bus_read(`RECEIVE_BUFFER_OFFSET);
			chk("fifo order", 8'(i == 3 ? 8'h14 : 8'h10 + i), d);
			if (i == 0) chk("full kept", 8'h01, {7'h0, full});
		end
		bus_read(`RECEIVE_BUFFER_OFFSET);
		bus_read(`CHANNEL_STATUS_OFFSET);
		chk("empty read", 8'h10, d);
		chk("flow pin free", 8'h00, {7'h0, pin_n});
		cfg.receiver_flow_control = 1'b0;
		pulse(5'h04);
		bus_read(`CHANNEL_STATUS_OFFSET);
		chk("error reset", 8'h00, d);
		cfg.pin_zero_function_select = 1'b1;
		cfg.transmitter_auto_negate = 1'b1;
		pulse(5'h02);
		pulse(5'h10);
		bus_read(`CHANNEL_STATUS_OFFSET);
		chk("tx enabled", 8'h0C, d);
		bus_write(8'h5A);
		chk("free after write", 8'h00, {7'h0, free});
		for (int i = 0; i < 100 && free !== 1'b1; i++) @(negedge mclk);
		chk("free reload", 8'h01, {7'h0, free});
		bus_write(8'hC3);
		bus_write(8'h99);
		wait_empty();
		chk("rts held", 8'h00, {7'h0, pin_n});
		repeat (80) @(negedge mclk);
		chk("rts negated", 8'h01, {7'h0, pin_n});
		chk("tx first", 8'h5A, remote_u.rx_q[0]);
		chk("tx second", 8'hC3, remote_u.rx_q[1]);
		pulse(5'h08);
		bus_write(8'h77);
		pulse(5'h10);
		cfg.clear_to_send_gate = 1'b1;
		cts_n = 1'b1;
		bus_write(8'h3C);
		repeat (300) @(negedge mclk);
		chk("cts hold", 8'h01, {7'h0, tx_line});
		chk("tx count", 8'h02, 8'(remote_u.rx_q.size()));
		cts_n = 1'b0;
		wait_empty();
		chk("tx gated", 8'h3C, remote_u.rx_q[2]);
		bus_read(`CHANNEL_STATUS_OFFSET);
		halt = 1'b1;
		bus_write(8'h55);
		bus_read(`RECEIVE_BUFFER_OFFSET);
		chk("halted read", 8'h0C, d);
		halt = 1'b0;
		bus_read(`CHANNEL_STATUS_OFFSET);
		chk("halted write", 8'h0C, d);
		cfg.pin_zero_function_select = 1'b0;
		pulse(5'h02);
		chk("pin set", 8'h00, {7'h0, pin_n});
		pulse(5'h01);
		chk("pin clear", 8'h01, {7'h0, pin_n});
		pulse(5'h02);
		rst_n = 1'b0;
		repeat (20) @(negedge mclk);
		rst_n = 1'b1;
		bus_read(`CHANNEL_STATUS_OFFSET);
		chk("reset status", 8'h00, d);
		chk("reset lines", 8'h03, {6'h0, tx_line, pin_n});
		print_verdict();
	end
endmodule : tb_top
bind uart_channel_buffers_status uart_channel_sva chk_u (.*);
